// ---- logic/msss_pkg.sv ----
// shared constants and types of the measurement start/stop sequencer
// assumes a single 10 MHz system clock

package msss_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    // least time a card write needs on the backplane
    localparam int ACCESS_NS = 300;
    localparam int ACC_CYC_I = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least settle time after the backplane clock is enabled
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC_I = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((ACC_CYC_I < 1) ? 1 : ACC_CYC_I);
    localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_CYC_I < 1) ? 1 : SETTLE_CYC_I);
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic CMD_STOP = 1'h0;
    localparam logic CMD_START = 1'h1;
    localparam logic KEEP_CLK_OFF = 1'h0;
    localparam logic KEEP_CLK_ON = 1'h1;
    localparam logic MODE_CONFIG = 1'h0;
    localparam logic MODE_MEASURE = 1'h1;
    localparam logic TRIG_CLEAR = 1'h0;
    localparam logic TRIG_ACTIVE = 1'h1;
    localparam logic BP_CLK_RESET = 1'h1;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_CLK_BIT = 1;

    typedef enum logic [2:0] {
        MSSS_IDLE,
        MSSS_CLK_ON,
        MSSS_CLR,
        MSSS_CFG,
        MSSS_MEAS,
        MSSS_TRIG,
        MSSS_CLK_OFF,
        MSSS_DONE
    } msss_state_t;

endpackage

// ---- logic/msss_walk_if.sv ----
// carrier between the sequencer and its card list walker
// assumes both ends share sys_clk

`timescale 1ns/1ps

interface msss_walk_if #(parameter int IDX_W = 3);
    logic load;
    logic load_rev;
    logic step;
    logic [IDX_W:0] len;
    logic [IDX_W-1:0] idx;
    logic rev;
    logic last;
    logic empty;

    modport ctrl (output load, load_rev, step, len, input idx, rev, last, empty);
    modport walk (input load, load_rev, step, len, output idx, rev, last, empty);
endinterface

// ---- logic/msss_sync.sv ----
// two-stage level synchroniser
// assumes the input is asynchronous to sys_clk

`timescale 1ns/1ps

module msss_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule

// ---- logic/msss_walker.sv ----
// card list index walker, forward or reverse
// assumes step is only given while the list is not empty

`timescale 1ns/1ps

module msss_walker #(
    parameter int IDX_W = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    msss_walk_if.walk w
);
    logic [IDX_W-1:0] idx_reg;
    logic rev_reg;
    logic [IDX_W-1:0] top_idx;
    logic [IDX_W-1:0] start_idx;

    assign top_idx = IDX_W'(w.len - 1'b1);
    assign start_idx = w.load_rev ? top_idx : '0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idx_reg <= '0;
            rev_reg <= 1'b0;
        end else if (w.load) begin
            idx_reg <= start_idx;
            rev_reg <= w.load_rev;
        end else if (w.step) begin
            idx_reg <= rev_reg ? IDX_W'(idx_reg - 1'b1) : IDX_W'(idx_reg + 1'b1);
        end
    end

    assign w.idx = idx_reg;
    assign w.rev = rev_reg;
    assign w.empty = (w.len == '0);
    assign w.last = rev_reg ? (idx_reg == '0) : (idx_reg == top_idx);
endmodule

// ---- logic/msss_top.sv ----
// measurement start/stop sequencer for backplane instrument cards
// assumes the command, list and query ports come from logic on sys_clk,
// the clock-present sense comes from a pin

`timescale 1ns/1ps

module msss_top
    import msss_pkg::*;
#(
    parameter int MAX_CARDS = 8,
    parameter int SLOT_W = 4,
    parameter int IDX_W = $clog2(MAX_CARDS)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_start,
    input wire logic cmd_keep_clk,
    input wire logic status_query,
    input wire logic [IDX_W:0] list_len,
    input wire logic [MAX_CARDS*SLOT_W-1:0] list_slots,
    input wire logic [(1<<SLOT_W)-1:0] continuous_mask,
    input wire logic bp_clk_sense,
    output logic bp_clk_en,
    output logic [SLOT_W-1:0] slot_select,
    output logic card_mode_select,
    output logic card_soft_trigger_control,
    output logic continuous_generate_select,
    output logic card_wr,
    output logic test_running,
    output logic status_valid,
    output logic [1:0] status_data
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [SLOT_W-1:0] slot_of(input logic [MAX_CARDS*SLOT_W-1:0] l,
                                                  input logic [IDX_W-1:0] i);
        return l[i*SLOT_W +: SLOT_W];
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    msss_state_t state_reg;
    msss_state_t state_next;
    logic [CNT_W-1:0] wait_reg;
    logic [CNT_W-1:0] wait_next;
    logic issued_reg;
    logic issued_next;
    logic keep_reg;
    logic stopping_reg;
    logic running_reg;
    logic was_run_reg;
    logic bp_clk_en_reg;
    logic [SLOT_W-1:0] slot_reg;
    logic mode_reg;
    logic trig_reg;
    logic cont_reg;
    logic card_wr_reg;
    logic status_valid_reg;
    logic [1:0] status_data_reg;
    logic issue;
    logic walk_load;
    logic walk_load_rev;
    logic walk_step;
    logic clk_present;

    msss_walk_if #(.IDX_W(IDX_W)) walk ();

    msss_walker #(.IDX_W(IDX_W)) u_walker (
        .sys_clk(sys_clk),
        .rst(rst),
        .w(walk)
    );

    msss_sync #(.W(1)) u_clk_sense (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(bp_clk_sense),
        .q(clk_present)
    );

    assign walk.load = walk_load;
    assign walk.load_rev = walk_load_rev;
    assign walk.step = walk_step;
    assign walk.len = list_len;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    wire accept = (state_reg == MSSS_IDLE) && cmd_valid;
    wire card_op = (state_reg == MSSS_CLR) || (state_reg == MSSS_CFG) ||
                   (state_reg == MSSS_MEAS) || (state_reg == MSSS_TRIG);
    // clearing leaves a measuring card in its mode until every trigger is off
    wire clr_mode = was_run_reg ? MODE_MEASURE : MODE_CONFIG;
    wire op_mode = ((state_reg == MSSS_MEAS) || (state_reg == MSSS_TRIG)) ? MODE_MEASURE :
                   (state_reg == MSSS_CLR) ? clr_mode : MODE_CONFIG;
    wire op_trig = (state_reg == MSSS_TRIG) ? TRIG_ACTIVE : TRIG_CLEAR;
    wire [SLOT_W-1:0] cur_slot = slot_of(list_slots, walk.idx);

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        issued_next = issued_reg;
        issue = 1'b0;
        walk_load = 1'b0;
        walk_load_rev = 1'b0;
        walk_step = 1'b0;
        case (state_reg)
            MSSS_IDLE: begin
                if (cmd_valid) begin
                    state_next = MSSS_CLK_ON;
                    wait_next = SETTLE_CYC - CNT_ONE;
                end
            end
            MSSS_CLK_ON: begin
                if (wait_reg != CNT_ZERO) begin
                    wait_next = wait_reg - CNT_ONE;
                end else if (walk.empty) begin
                    state_next = stopping_reg ? MSSS_DONE : MSSS_CLK_OFF;
                end else begin
                    state_next = MSSS_CLR;
                    walk_load = 1'b1;
                end
            end
            MSSS_CLR, MSSS_CFG, MSSS_MEAS, MSSS_TRIG: begin
                if (!issued_reg) begin
                    issue = 1'b1;
                    issued_next = 1'b1;
                    wait_next = ACC_CYC - CNT_ONE;
                end else if (wait_reg != CNT_ZERO) begin
                    wait_next = wait_reg - CNT_ONE;
                end else if (!walk.last) begin
                    issued_next = 1'b0;
                    walk_step = 1'b1;
                end else begin
                    issued_next = 1'b0;
                    walk_load = 1'b1;
                    case (state_reg)
                        MSSS_CLR: begin
                            // clearing precedes any mode change
                            state_next = MSSS_CFG;
                        end
                        MSSS_CFG: begin
                            state_next = stopping_reg ? MSSS_DONE : MSSS_MEAS;
                            walk_load_rev = 1'b1;
                        end
                        MSSS_MEAS: begin
                            // mode set before trigger
                            state_next = MSSS_TRIG;
                            walk_load_rev = 1'b1;
                        end
                        default: begin
                            state_next = MSSS_CLK_OFF;
                        end
                    endcase
                end
            end
            MSSS_CLK_OFF: begin
                state_next = MSSS_DONE;
            end
            default: begin
                state_next = MSSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= MSSS_IDLE;
            wait_reg <= CNT_ZERO;
            issued_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            issued_reg <= issued_next;
        end
    end

    // ------------------------------------------------------------
    // command latch and running flag
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            keep_reg <= KEEP_CLK_OFF;
            stopping_reg <= 1'b0;
            running_reg <= 1'b0;
            was_run_reg <= 1'b0;
        end else if (accept) begin
            was_run_reg <= running_reg;
            keep_reg <= cmd_keep_clk;
            stopping_reg <= (cmd_start == CMD_STOP);
            running_reg <= running_reg || (cmd_start == CMD_START);
        end else if (state_reg == MSSS_DONE && stopping_reg) begin
            running_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // backplane clock
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bp_clk_en_reg <= BP_CLK_RESET;
        end else if (accept) begin
            bp_clk_en_reg <= 1'b1;
        end else if (state_reg == MSSS_CLK_OFF && keep_reg == KEEP_CLK_OFF) begin
            bp_clk_en_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // card writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            card_wr_reg <= 1'b0;
            slot_reg <= '0;
            mode_reg <= MODE_CONFIG;
            trig_reg <= TRIG_CLEAR;
            cont_reg <= 1'b0;
        end else begin
            // strobes only leave after the clock settle wait
            card_wr_reg <= issue;
            if (issue) begin
                slot_reg <= cur_slot;
                mode_reg <= op_mode;
                trig_reg <= op_trig;
                // continuous cards ignore loop counts once triggered
                cont_reg <= continuous_mask[cur_slot];
            end
        end
    end

    // ------------------------------------------------------------
    // status query
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_valid_reg <= 1'b0;
            status_data_reg <= 2'h0;
        end else begin
            status_valid_reg <= status_query;
            if (status_query) begin
                status_data_reg[STAT_RUN_BIT] <= running_reg;
                status_data_reg[STAT_CLK_BIT] <= clk_present;
            end
        end
    end

    assign bp_clk_en = bp_clk_en_reg;
    assign slot_select = slot_reg;
    assign card_mode_select = mode_reg;
    assign card_soft_trigger_control = trig_reg;
    assign continuous_generate_select = cont_reg;
    assign card_wr = card_wr_reg;
    assign test_running = running_reg;
    assign status_valid = status_valid_reg;
    assign status_data = status_data_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_clear_trig_zero: assert property (
        (issue && state_reg == MSSS_CLR) |=> (card_wr_reg && trig_reg == TRIG_CLEAR && mode_reg == clr_mode))
        else $error("trigger not cleared in clear step");
    chk_cfg_forward: assert property (
        (issue && state_reg == MSSS_CFG) |-> (!walk.rev ##1 (card_wr_reg && mode_reg == MODE_CONFIG)))
        else $error("configuration step not forward");
    chk_meas_reverse: assert property (
        (issue && state_reg == MSSS_MEAS) |-> (walk.rev ##1 mode_reg == MODE_MEASURE))
        else $error("measurement step not reverse");
    chk_first_trig_last: assert property (
        (issue && state_reg == MSSS_TRIG && walk.last) |=>
            (slot_reg == slot_of(list_slots, '0) && trig_reg == TRIG_ACTIVE))
        else $error("first card not triggered last");
    chk_access_gap: assert property (
        card_wr_reg |=> !card_wr_reg ##1 !card_wr_reg)
        else $error("card writes too close");
    chk_write_clk_on: assert property (
        card_wr_reg |-> bp_clk_en_reg)
        else $error("card write with clock off");
    chk_write_in_step: assert property (
        card_wr_reg |-> $past(card_op))
        else $error("card write outside a card step");
    chk_clk_off_end: assert property (
        (state_reg == MSSS_CLK_OFF && !keep_reg) |=> (!bp_clk_en_reg && state_reg == MSSS_DONE))
        else $error("clock not switched off");
    chk_clk_kept: assert property (
        $fell(bp_clk_en_reg) |-> ($past(keep_reg) == KEEP_CLK_OFF && !$past(stopping_reg)))
        else $error("kept clock switched off");
    chk_start_clk_on: assert property (
        accept |=> bp_clk_en_reg [*2])
        else $error("clock not enabled on command");
    chk_status_reply: assert property (
        status_query |=> (status_valid_reg && status_data_reg[STAT_RUN_BIT] == $past(running_reg)))
        else $error("status reply wrong");
    chk_ready_after_stop: assert property (
        $fell(running_reg) |-> ($past(state_reg) == MSSS_DONE && $past(stopping_reg)))
        else $error("ready before stop finished");
endmodule

// ---- dv/msss_card_model.sv ----
// backplane card model: logs every card write, reports the clock sense
// assumes card writes arrive as one-cycle card_wr pulses on sys_clk

`timescale 1ns/1ps

module msss_card_model (
    input wire logic sys_clk,
    input wire logic bp_clk_en,
    input wire logic [3:0] slot_select,
    input wire logic card_mode_select,
    input wire logic card_soft_trigger_control,
    input wire logic continuous_generate_select,
    input wire logic card_wr,
    output logic bp_clk_sense
);
    logic [6:0] log_q[$];
    int n_bad = 0;
    logic [15:0] gen_on = 16'h0000;
    logic [15:0] mode_st = 16'h0000;
    logic [15:0] trig_st = 16'h0000;

    // clock present only while enabled
    assign bp_clk_sense = bp_clk_en;

    always @(posedge sys_clk) begin
        if (card_wr === 1'b1) begin
            if (bp_clk_en !== 1'b1) n_bad++;
            // a triggered card may not change mode
            if (card_mode_select !== mode_st[slot_select] && trig_st[slot_select]) n_bad++;
            // a trigger only in measurement mode
            if (card_soft_trigger_control && !card_mode_select) n_bad++;
            log_q.push_back({slot_select, card_mode_select, card_soft_trigger_control,
                             continuous_generate_select});
            mode_st[slot_select] <= card_mode_select;
            trig_st[slot_select] <= card_soft_trigger_control;
            // card generates only once in measure mode and triggered
            gen_on[slot_select] <= card_mode_select & card_soft_trigger_control;
        end
    end
endmodule

// ---- dv/test_msss.sv ----
// testbench of the measurement start/stop sequencer
// assumes the card model answers every write and senses the clock enable

`timescale 1ns/1ps

module test_msss;
    import msss_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_start = 1'b0;
    logic cmd_keep_clk = 1'b0;
    logic status_query = 1'b0;
    logic [3:0] list_len = 4'h0;
    logic [3:0] lst[8];
    logic [31:0] list_slots;
    logic [15:0] continuous_mask = 16'h0000;
    logic bp_clk_sense;
    logic bp_clk_en;
    logic [3:0] slot_select;
    logic card_mode_select;
    logic card_soft_trigger_control;
    logic continuous_generate_select;
    logic card_wr;
    logic test_running;
    logic status_valid;
    logic [1:0] status_data;
    logic [1:0] st_d;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #50 sys_clk = ~sys_clk;

    always_comb begin
        for (int i = 0; i < 8; i++) list_slots[i*4 +: 4] = lst[i];
    end

    msss_top dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_start(cmd_start),
        .cmd_keep_clk(cmd_keep_clk), .status_query(status_query), .list_len(list_len),
        .list_slots(list_slots), .continuous_mask(continuous_mask), .bp_clk_sense(bp_clk_sense),
        .bp_clk_en(bp_clk_en), .slot_select(slot_select), .card_mode_select(card_mode_select),
        .card_soft_trigger_control(card_soft_trigger_control),
        .continuous_generate_select(continuous_generate_select), .card_wr(card_wr),
        .test_running(test_running), .status_valid(status_valid), .status_data(status_data));

    msss_card_model model (.sys_clk(sys_clk), .bp_clk_en(bp_clk_en), .slot_select(slot_select),
        .card_mode_select(card_mode_select), .card_soft_trigger_control(card_soft_trigger_control),
        .continuous_generate_select(continuous_generate_select), .card_wr(card_wr),
        .bp_clk_sense(bp_clk_sense));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic query(output logic [1:0] d);
        @(negedge sys_clk) status_query = 1'b1;
        @(negedge sys_clk) status_query = 1'b0;
        chk({7'h00, status_valid}, 8'h01);
        d = status_data;
    endtask

    // expected write entry: {clear step, slot, mode, trigger, continuous}
    function automatic logic [7:0] ent(logic c, logic [3:0] s, logic m, logic t);
        return {c, s, m, t, continuous_mask[s]};
    endfunction

    task automatic run_cmd(input logic st, input logic keep);
        logic [7:0] e[$];
        logic [7:0] seen;
        logic pm;
        int n;
        n = int'(list_len);
        // listed cards measure while a run is on
        pm = test_running ? MODE_MEASURE : MODE_CONFIG;
        model.log_q.delete();
        for (int i = 0; i < n; i++) e.push_back(ent(1'b1, lst[i], pm, TRIG_CLEAR));
        for (int i = 0; i < n; i++) e.push_back(ent(1'b0, lst[i], MODE_CONFIG, TRIG_CLEAR));
        if (st) begin
            for (int i = n - 1; i >= 0; i--) e.push_back(ent(1'b0, lst[i], MODE_MEASURE, TRIG_CLEAR));
            for (int i = n - 1; i >= 0; i--) e.push_back(ent(1'b0, lst[i], MODE_MEASURE, TRIG_ACTIVE));
        end
        @(negedge sys_clk) begin
            cmd_valid = 1'b1;
            cmd_start = st;
            cmd_keep_clk = keep;
        end
        @(negedge sys_clk) cmd_valid = 1'b0;
        chk({7'h00, bp_clk_en}, 8'h01);
        query(st_d);
        chk({7'h00, st_d[STAT_RUN_BIT]}, 8'h01);
        for (int w = 0; w < 400 && model.log_q.size() < e.size(); w++) @(negedge sys_clk);
        repeat (20) @(negedge sys_clk);
        chk(8'(model.log_q.size()), 8'(e.size()));
        for (int k = 0; k < e.size() && k < model.log_q.size(); k++) begin
            seen = {e[k][7], model.log_q[k]};
            chk(seen, e[k]);
        end
        for (int i = 0; i < n; i++) chk({7'h00, model.gen_on[lst[i]]}, {7'h00, st});
        chk({7'h00, bp_clk_en}, {7'h00, ~st | keep});
        chk({7'h00, test_running}, {7'h00, st});
        query(st_d);
        chk({6'h00, st_d}, {6'h00, ~st | keep, st});
        $display("test %s keep=%0d cards=%0d done", st ? "start" : "stop", keep, n);
    endtask

    initial begin
        for (int i = 0; i < 8; i++) lst[i] = 4'(15 - i);
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        chk({6'h00, bp_clk_en, test_running}, 8'h02);
        repeat (3) @(negedge sys_clk);
        query(st_d);
        chk({6'h00, st_d}, 8'h02);
        $display("test reset done");
        // two cards, clock switched off after the start, left on after the stop
        lst[0] = 4'h0;
        lst[1] = 4'h2;
        list_len = 4'h2;
        continuous_mask = 16'h0004;
        run_cmd(CMD_START, KEEP_CLK_OFF);
        run_cmd(CMD_STOP, KEEP_CLK_OFF);
        // full list, clock kept on
        for (int i = 0; i < 8; i++) lst[i] = 4'(15 - i);
        list_len = 4'h8;
        continuous_mask = 16'ha5c3;
        run_cmd(CMD_START, KEEP_CLK_ON);
        run_cmd(CMD_STOP, KEEP_CLK_OFF);
        // empty list
        list_len = 4'h0;
        run_cmd(CMD_START, KEEP_CLK_OFF);
        run_cmd(CMD_STOP, KEEP_CLK_ON);
        chk(8'(model.n_bad), 8'h00);
        test_done();
    end
endmodule
